// ### design/ufc_pkg.sv
/*
 Constants, field positions and types shared by the UART channel data path.
 Assumes one system clock and a 16X sampling enable derived from it.
*/
// How it works
// - Each written byte goes out as start, data LSB first, parity, stop.
// - With FIFO enabled every holding write lands in the 64-byte transmit FIFO.
// - Non-FIFO: holding-empty sets on move to shifter; raises transmit-empty interrupt.
// - Non-FIFO: transmitter-empty sets only when the shifter is idle.
// - FIFO: holding-empty means FIFO empty; interrupt when level under trigger.
// - FIFO: transmitter-empty needs both FIFO and shifter empty.
// - Falling edge starts count; after eight ticks start bit checked still low.
// - Bits sampled mid-bit; parity, framing, break reported for the head byte.
// - Receive FIFO holds 64 entries of eight data plus three error bits.
// - Reading receive holding pops the FIFO and refreshes error status a clock later.
// - Data-ready interrupt per character or at FIFO trigger level.
// - Timeout when data waits four word lengths plus twelve bit times.
// - Channel holding locations at 0x00, 0x10, 0x20, 0x30; byte accesses only.
// - Modem-control select bit picks RTS/CTS or DTR/DSR pair.
// - Enhanced-feature bit lets receive fill level drive the RTS or DTR output.
// - Tables A to C: deassert at next trigger up, reassert at next down.
// - Table D: deassert at trigger plus hysteresis, reassert below trigger minus it.
// - Receiver keeps storing characters after deassertion until the FIFO is full.
// - Each RTS/DTR output transition sets the interrupt source bit when enabled.
// - CTS/DSR high stops transmit after the current stop bit; low resumes.
// - Each CTS/DSR input transition sets the interrupt source bit when enabled.
// - One bit time is sixteen periods of the 16X sampling enable.
package ufc_pkg;
    localparam int FIFO_DEPTH = 64;
    localparam int LVL_W = 7;
    localparam logic [7:0] CH0_OFFSET = 8'h00;
    localparam logic [7:0] CH1_OFFSET = 8'h10;
    localparam logic [7:0] CH2_OFFSET = 8'h20;
    localparam logic [7:0] CH3_OFFSET = 8'h30;
    localparam int TICKS_PER_BIT = 16;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] START_MID = 4'h7;
    localparam int MIN_WORD_BITS = 5;
    localparam int TIMEOUT_WORDS = 4;
    localparam int TIMEOUT_EXTRA_BITS = 12;
    localparam int LCR_WLEN_LSB = 0;
    localparam int LCR_STOP2 = 2;
    localparam int LCR_PAR_EN = 3;
    localparam int LCR_PAR_EVEN = 4;
    localparam int LSR_DATA_READY = 0;
    localparam int LSR_PAR_ERR = 2;
    localparam int LSR_FRM_ERR = 3;
    localparam int LSR_BREAK = 4;
    localparam int LSR_THR_EMPTY = 5;
    localparam int LSR_TX_EMPTY = 6;
    localparam int IER_RX_DATA = 0;
    localparam int IER_TX_EMPTY = 1;
    localparam int IER_RTS_INT = 6;
    localparam int IER_CTS_INT = 7;
    localparam int FCR_FIFO_EN = 0;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_FLOW_SEL = 2;
    localparam int EFR_UNLOCK = 4;
    localparam int EFR_AUTO_RTS = 6;
    localparam int EFR_AUTO_CTS = 7;
    localparam int ISR_RX_DATA = 0;
    localparam int ISR_TX_EMPTY = 1;
    localparam int ISR_RX_TIMEOUT = 2;
    localparam int ISR_FLOW = 5;

    typedef struct packed {
        logic brk;
        logic frm;
        logic par;
        logic [7:0] data;
    } ufc_rx_entry_t;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ufc_tx_state_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ufc_rx_state_t;
endpackage

// ### design/ufc_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides and a fill level.
 Assumes DEPTH is a power of two; limit_one_i shrinks it to one word.
*/
`timescale 1ns/100ps
module ufc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic limit_one_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [AW:0] level_o
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign out_valid_o = (count_ff != '0);
    assign in_ready_o = limit_one_i ? (count_ff == '0) : (count_ff != (AW+1)'(DEPTH));
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_data_o = mem[rd_ptr_ff];
    assign level_o = count_ff;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            wr_ptr_ff <= push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
            rd_ptr_ff <= pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
            count_ff <= (AW+1)'(count_ff + (AW+1)'(push) - (AW+1)'(pop));
        end
    end
endmodule

// ### design/ufc_channel.sv
/*
 One UART channel data path: holding locations on the byte bus, transmit and
 receive FIFOs, serialiser, receiver, timeout and automatic flow control.
 Assumes all inputs synchronous to CLK_SYS_I; configuration bytes are held
 by registers outside this block.
*/
`timescale 1ns/100ps
module ufc_channel
    import ufc_pkg::*;
#(
    parameter logic [7:0] CH_BASE = CH0_OFFSET
) (
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic [7:0] BUS_ADDR_I,
    input wire logic BUS_WR_I,
    input wire logic BUS_RD_I,
    input wire logic [7:0] BUS_WDATA_I,
    output logic [7:0] BUS_RDATA_O,
    output logic BUS_WR_READY_O,
    input wire logic [7:0] LINE_CONTROL_I,
    input wire logic [7:0] FIFO_CONTROL_I,
    input wire logic [7:0] INT_ENABLE_I,
    input wire logic [7:0] MODEM_CONTROL_I,
    input wire logic [7:0] ENH_FEATURE_I,
    input wire logic [7:0] FEATURE_CONTROL_I,
    input wire logic TRIG_TABLE_D_I,
    input wire logic [6:0] RX_TRIGGER_I,
    input wire logic [6:0] RX_TRIG_UP_I,
    input wire logic [6:0] RX_TRIG_DOWN_I,
    input wire logic [6:0] TX_TRIGGER_I,
    input wire logic [15:0] BAUD_DIVISOR_I,
    input wire logic FLOW_INT_CLR_I,
    output logic TX_O,
    input wire logic RX_I,
    output logic RTS_N_O,
    output logic DTR_N_O,
    input wire logic CTS_N_I,
    input wire logic DSR_N_I,
    output logic [7:0] LINE_STATUS_O,
    output logic [7:0] INT_SOURCE_O
);
    ////////////////////////////////////////////////////////////////////////////
    // Configuration decode
    wire fifo_en = FIFO_CONTROL_I[FCR_FIFO_EN];
    wire [1:0] wlen = LINE_CONTROL_I[LCR_WLEN_LSB +: 2];
    wire [2:0] last_bit = 3'(MIN_WORD_BITS - 1) + 3'(wlen);
    wire par_en = LINE_CONTROL_I[LCR_PAR_EN];
    wire par_even = LINE_CONTROL_I[LCR_PAR_EVEN];
    wire two_stop = LINE_CONTROL_I[LCR_STOP2];
    wire use_dtr = MODEM_CONTROL_I[MCR_FLOW_SEL];
    wire auto_rts = ENH_FEATURE_I[EFR_AUTO_RTS];
    wire auto_cts = ENH_FEATURE_I[EFR_AUTO_CTS];
    wire ext_int = ENH_FEATURE_I[EFR_UNLOCK];
    wire [3:0] hyst = FEATURE_CONTROL_I[3:0];

    ////////////////////////////////////////////////////////////////////////////
    // 16X sampling enable
    logic [15:0] baud_cnt_ff;
    wire [15:0] baud_inc = 16'(baud_cnt_ff + 16'h1);
    wire tick16 = (baud_inc >= BAUD_DIVISOR_I);

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            baud_cnt_ff <= '0;
        end else begin
            baud_cnt_ff <= tick16 ? '0 : baud_inc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode and FIFOs
    wire hit = (BUS_ADDR_I == CH_BASE);
    wire tx_in_ready;
    wire tx_valid;
    wire [7:0] tx_head;
    wire [LVL_W-1:0] tx_lvl;
    logic tx_pop;
    wire wr_take = hit & BUS_WR_I;
    wire rd_take = hit & BUS_RD_I;
    wire rx_valid;
    wire rx_in_ready;
    ufc_rx_entry_t rx_head;
    ufc_rx_entry_t rx_entry;
    wire [LVL_W-1:0] rx_lvl;
    logic rx_push;

    assign BUS_WR_READY_O = tx_in_ready;

    ufc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .clk_i(CLK_SYS_I),
        .arst_n_i(ARST_N_I),
        .limit_one_i(!fifo_en),
        .in_valid_i(wr_take),
        .in_ready_o(tx_in_ready),
        .in_data_i(BUS_WDATA_I),
        .out_valid_o(tx_valid),
        .out_ready_i(tx_pop),
        .out_data_o(tx_head),
        .level_o(tx_lvl)
    );

    ufc_fifo #(.WIDTH($bits(ufc_rx_entry_t)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clk_i(CLK_SYS_I),
        .arst_n_i(ARST_N_I),
        .limit_one_i(!fifo_en),
        .in_valid_i(rx_push),
        .in_ready_o(rx_in_ready),
        .in_data_i(rx_entry),
        .out_valid_o(rx_valid),
        .out_ready_i(rd_take),
        .out_data_o(rx_head),
        .level_o(rx_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter
    ufc_tx_state_t tx_state_ff, nxt_tx_state;
    logic [3:0] tx_tick_ff, nxt_tx_tick;
    logic [7:0] tx_shift_ff, nxt_tx_shift;
    logic [2:0] tx_bit_ff, nxt_tx_bit;
    logic tx_par_ff, nxt_tx_par;
    logic tx_stop_ff, nxt_tx_stop;
    logic tx_line_ff, nxt_tx_line;
    wire cts_in = use_dtr ? DSR_N_I : CTS_N_I;
    wire cts_hold = auto_cts & cts_in;
    wire tx_bit_end = tick16 & (tx_tick_ff == TICK_LAST);

    always_comb begin
        nxt_tx_state = tx_state_ff;
        nxt_tx_tick = tx_tick_ff;
        nxt_tx_shift = tx_shift_ff;
        nxt_tx_bit = tx_bit_ff;
        nxt_tx_par = tx_par_ff;
        nxt_tx_stop = tx_stop_ff;
        nxt_tx_line = tx_line_ff;
        tx_pop = 1'b0;
        if (tick16) begin
            nxt_tx_tick = 4'(tx_tick_ff + 4'h1);
        end
        case (tx_state_ff)
            TX_IDLE: begin
                nxt_tx_tick = '0;
                nxt_tx_line = 1'b1;
                if (tick16 && tx_valid && !cts_hold) begin
                    tx_pop = 1'b1;
                    nxt_tx_shift = tx_head;
                    nxt_tx_par = !par_even;
                    nxt_tx_line = 1'b0;
                    nxt_tx_state = TX_START;
                end
            end
            TX_START: begin
                if (tx_bit_end) begin
                    nxt_tx_line = tx_shift_ff[0];
                    nxt_tx_bit = '0;
                    nxt_tx_state = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_bit_end) begin
                    nxt_tx_par = tx_par_ff ^ tx_shift_ff[0];
                    nxt_tx_shift = {1'b0, tx_shift_ff[7:1]};
                    nxt_tx_bit = 3'(tx_bit_ff + 3'h1);
                    nxt_tx_line = tx_shift_ff[1];
                    nxt_tx_stop = 1'b0;
                    if (tx_bit_ff == last_bit) begin
                        nxt_tx_line = par_en ? (tx_par_ff ^ tx_shift_ff[0]) : 1'b1;
                        nxt_tx_state = par_en ? TX_PARITY : TX_STOP;
                    end
                end
            end
            TX_PARITY: begin
                if (tx_bit_end) begin
                    nxt_tx_line = 1'b1;
                    nxt_tx_state = TX_STOP;
                end
            end
            TX_STOP: begin
                if (tx_bit_end) begin
                    nxt_tx_stop = 1'b1;
                    if (!two_stop || tx_stop_ff) begin
                        nxt_tx_state = TX_IDLE;
                    end
                end
            end
            default: begin
                nxt_tx_state = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tx_state_ff <= TX_IDLE;
            tx_tick_ff <= '0;
            tx_shift_ff <= '0;
            tx_bit_ff <= '0;
            tx_par_ff <= 1'b0;
            tx_stop_ff <= 1'b0;
            tx_line_ff <= 1'b1;
        end else begin
            tx_state_ff <= nxt_tx_state;
            tx_tick_ff <= nxt_tx_tick;
            tx_shift_ff <= nxt_tx_shift;
            tx_bit_ff <= nxt_tx_bit;
            tx_par_ff <= nxt_tx_par;
            tx_stop_ff <= nxt_tx_stop;
            tx_line_ff <= nxt_tx_line;
        end
    end

    assign TX_O = tx_line_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Receiver
    ufc_rx_state_t rx_state_ff, nxt_rx_state;
    logic [3:0] rx_tick_ff, nxt_rx_tick;
    logic [7:0] rx_data_ff, nxt_rx_data;
    logic [2:0] rx_bit_ff, nxt_rx_bit;
    logic rx_par_ff, nxt_rx_par;
    logic rx_perr_ff, nxt_rx_perr;
    logic rx_ones_ff, nxt_rx_ones;
    logic rx_prev_ff;
    wire rx_bit_end = tick16 & (rx_tick_ff == TICK_LAST);

    always_comb begin
        nxt_rx_state = rx_state_ff;
        nxt_rx_tick = rx_tick_ff;
        nxt_rx_data = rx_data_ff;
        nxt_rx_bit = rx_bit_ff;
        nxt_rx_par = rx_par_ff;
        nxt_rx_perr = rx_perr_ff;
        nxt_rx_ones = rx_ones_ff;
        rx_push = 1'b0;
        rx_entry = '{brk: !(rx_ones_ff | RX_I), frm: !RX_I, par: rx_perr_ff, data: rx_data_ff};
        if (tick16) begin
            nxt_rx_tick = 4'(rx_tick_ff + 4'h1);
        end
        case (rx_state_ff)
            RX_IDLE: begin
                nxt_rx_tick = '0;
                if (tick16 && rx_prev_ff && !RX_I) begin
                    nxt_rx_state = RX_START;
                end
            end
            RX_START: begin
                if (tick16 && rx_tick_ff == START_MID) begin
                    nxt_rx_tick = '0;
                    nxt_rx_bit = '0;
                    nxt_rx_data = '0;
                    nxt_rx_par = !par_even;
                    nxt_rx_perr = 1'b0;
                    nxt_rx_ones = 1'b0;
                    nxt_rx_state = RX_I ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_bit_end) begin
                    nxt_rx_data[rx_bit_ff] = RX_I;
                    nxt_rx_par = rx_par_ff ^ RX_I;
                    nxt_rx_ones = rx_ones_ff | RX_I;
                    nxt_rx_bit = 3'(rx_bit_ff + 3'h1);
                    if (rx_bit_ff == last_bit) begin
                        nxt_rx_state = par_en ? RX_PARITY : RX_STOP;
                    end
                end
            end
            RX_PARITY: begin
                if (rx_bit_end) begin
                    nxt_rx_perr = rx_par_ff ^ RX_I;
                    nxt_rx_ones = rx_ones_ff | RX_I;
                    nxt_rx_state = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_bit_end) begin
                    rx_push = 1'b1;
                    nxt_rx_state = RX_IDLE;
                end
            end
            default: begin
                nxt_rx_state = RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rx_state_ff <= RX_IDLE;
            rx_tick_ff <= '0;
            rx_data_ff <= '0;
            rx_bit_ff <= '0;
            rx_par_ff <= 1'b0;
            rx_perr_ff <= 1'b0;
            rx_ones_ff <= 1'b0;
            rx_prev_ff <= 1'b1;
        end else begin
            rx_state_ff <= nxt_rx_state;
            rx_tick_ff <= nxt_rx_tick;
            rx_data_ff <= nxt_rx_data;
            rx_bit_ff <= nxt_rx_bit;
            rx_par_ff <= nxt_rx_par;
            rx_perr_ff <= nxt_rx_perr;
            rx_ones_ff <= nxt_rx_ones;
            rx_prev_ff <= tick16 ? RX_I : rx_prev_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive timeout, counted in 16X ticks
    logic [10:0] to_cnt_ff;
    logic to_flag_ff;
    wire [10:0] to_limit = 11'((TIMEOUT_WORDS * (MIN_WORD_BITS + int'(wlen)) + TIMEOUT_EXTRA_BITS) * TICKS_PER_BIT);
    wire to_restart = rx_push | rd_take | !rx_valid;
    wire to_hit = tick16 & (to_cnt_ff == to_limit);

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            to_cnt_ff <= '0;
            to_flag_ff <= 1'b0;
        end else begin
            to_cnt_ff <= to_restart ? '0 : (tick16 && !to_flag_ff) ? 11'(to_cnt_ff + 11'h1) : to_cnt_ff;
            to_flag_ff <= to_restart ? 1'b0 : (to_flag_ff | to_hit);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Automatic receive flow control
    logic flow_ok_ff;
    wire [7:0] hi_d = 8'(RX_TRIGGER_I) + 8'(hyst);
    wire [7:0] hi_mark = TRIG_TABLE_D_I ? hi_d : 8'(RX_TRIG_UP_I);
    wire lvl_high = (8'(rx_lvl) >= hi_mark);
    wire lvl_low_d = ((8'(rx_lvl) + 8'(hyst)) < 8'(RX_TRIGGER_I));
    wire lvl_low = TRIG_TABLE_D_I ? lvl_low_d : (rx_lvl <= RX_TRIG_DOWN_I);
    wire rts_grant = !auto_rts | flow_ok_ff;
    // Host bit is the master switch; auto flow only gates it
    wire rts_on = MODEM_CONTROL_I[MCR_RTS] & (use_dtr | rts_grant);
    wire dtr_on = MODEM_CONTROL_I[MCR_DTR] & (!use_dtr | rts_grant);
    logic rts_n_ff;
    logic dtr_n_ff;
    logic cts_prev_ff;
    logic flow_int_ff;
    wire sel_out_n = use_dtr ? dtr_n_ff : rts_n_ff;
    wire sel_out_nxt = use_dtr ? !dtr_on : !rts_on;
    wire out_edge = INT_ENABLE_I[IER_RTS_INT] & ext_int & (sel_out_nxt != sel_out_n);
    wire in_edge = INT_ENABLE_I[IER_CTS_INT] & ext_int & (cts_in != cts_prev_ff);

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            flow_ok_ff <= 1'b1;
            rts_n_ff <= 1'b1;
            dtr_n_ff <= 1'b1;
            cts_prev_ff <= 1'b1;
            flow_int_ff <= 1'b0;
        end else begin
            flow_ok_ff <= flow_ok_ff ? !lvl_high : lvl_low;
            rts_n_ff <= !rts_on;
            dtr_n_ff <= !dtr_on;
            cts_prev_ff <= cts_in;
            // Set wins over a same-cycle clear
            flow_int_ff <= out_edge | in_edge | (flow_int_ff & !FLOW_INT_CLR_I);
        end
    end

    assign RTS_N_O = rts_n_ff;
    assign DTR_N_O = dtr_n_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Status and read data
    logic [7:0] rdata_ff;
    logic [7:0] lsr_ff;
    logic [7:0] isr_ff;
    logic [7:0] lsr_nxt;
    logic [7:0] isr_nxt;
    wire thr_empty = !tx_valid;
    wire tx_all_empty = thr_empty & (tx_state_ff == TX_IDLE);
    wire tx_int = fifo_en ? (tx_lvl < TX_TRIGGER_I) : thr_empty;
    wire rx_int = fifo_en ? (rx_lvl >= RX_TRIGGER_I) & rx_valid : rx_valid;

    always_comb begin
        lsr_nxt = '0;
        lsr_nxt[LSR_DATA_READY] = rx_valid;
        lsr_nxt[LSR_PAR_ERR] = rx_valid & rx_head.par;
        lsr_nxt[LSR_FRM_ERR] = rx_valid & rx_head.frm;
        lsr_nxt[LSR_BREAK] = rx_valid & rx_head.brk;
        lsr_nxt[LSR_THR_EMPTY] = thr_empty;
        lsr_nxt[LSR_TX_EMPTY] = tx_all_empty;
        isr_nxt = '0;
        isr_nxt[ISR_RX_DATA] = INT_ENABLE_I[IER_RX_DATA] & rx_int;
        isr_nxt[ISR_TX_EMPTY] = INT_ENABLE_I[IER_TX_EMPTY] & tx_int;
        isr_nxt[ISR_RX_TIMEOUT] = INT_ENABLE_I[IER_RX_DATA] & to_flag_ff;
        isr_nxt[ISR_FLOW] = flow_int_ff;
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_ff <= '0;
            lsr_ff <= '0;
            isr_ff <= '0;
        end else begin
            rdata_ff <= rd_take ? (rx_valid ? rx_head.data : '0) : rdata_ff;
            lsr_ff <= lsr_nxt;
            isr_ff <= isr_nxt;
        end
    end

    assign BUS_RDATA_O = rdata_ff;
    assign LINE_STATUS_O = lsr_ff;
    assign INT_SOURCE_O = isr_ff;
endmodule

// ### testbench/ufc_channel_props.sv
/* Port checker for one UART channel.
   Assumes channel base 0x00 and the bind below. */
`timescale 1ns/100ps
module ufc_channel_props (
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic [7:0] BUS_ADDR_I,
    input wire logic BUS_WR_I,
    input wire logic BUS_RD_I,
    input wire logic [7:0] BUS_RDATA_O,
    input wire logic BUS_WR_READY_O,
    input wire logic [7:0] FIFO_CONTROL_I,
    input wire logic [7:0] INT_ENABLE_I,
    input wire logic [7:0] MODEM_CONTROL_I,
    input wire logic [7:0] ENH_FEATURE_I,
    input wire logic TX_O,
    input wire logic RTS_N_O,
    input wire logic CTS_N_I,
    input wire logic [7:0] LINE_STATUS_O,
    input wire logic [7:0] INT_SOURCE_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I);
    sequence wr_hit;
        BUS_WR_I && BUS_ADDR_I == 8'h00 && BUS_WR_READY_O;
    endsequence
    bit_len_a: assert property ($fell(TX_O) |-> !TX_O [*8])
        else $error("short bit");
    tx_busy_a: assert property (wr_hit |-> ##2 !LINE_STATUS_O[6])
        else $error("idle after write");
    one_word_a: assert property (wr_hit ##0 !FIFO_CONTROL_I[0] |=> !BUS_WR_READY_O)
        else $error("second word taken");
    rd_hold_a: assert property (!(BUS_RD_I && BUS_ADDR_I == 8'h00) |=> $stable(BUS_RDATA_O))
        else $error("read data moved");
    rts_level_a: assert property ((!ENH_FEATURE_I[6] && !MODEM_CONTROL_I[2]
        && $stable(MODEM_CONTROL_I)) [*3] |-> RTS_N_O == !MODEM_CONTROL_I[1]) else $error("rts level");
    rts_int_a: assert property ($changed(RTS_N_O) && INT_ENABLE_I[6] && ENH_FEATURE_I[4]
        |-> ##[0:2] INT_SOURCE_O[5]) else $error("no rts interrupt");
    cts_int_a: assert property ($changed(CTS_N_I) && INT_ENABLE_I[7] && ENH_FEATURE_I[4]
        |-> ##[1:4] INT_SOURCE_O[5]) else $error("no cts interrupt");
    tx_mask_a: assert property (!INT_ENABLE_I[1] |=> !INT_SOURCE_O[1])
        else $error("masked tx interrupt");
endmodule
////////////////////////////////////////
bind ufc_channel ufc_channel_props u_ufc_channel_props (.CLK_SYS_I, .ARST_N_I, .BUS_ADDR_I, .BUS_WR_I,
    .BUS_RD_I, .BUS_RDATA_O, .BUS_WR_READY_O, .FIFO_CONTROL_I, .INT_ENABLE_I, .MODEM_CONTROL_I,
    .ENH_FEATURE_I, .TX_O, .RTS_N_O, .CTS_N_I, .LINE_STATUS_O, .INT_SOURCE_O);

// ### testbench/ufc_remote.sv
/* Remote UART on the serial pair, eight data bits, no parity.
   Assumes one 16X tick per clock. */
`timescale 1ns/100ps
module ufc_remote (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o = 1'b1
);
    logic [7:0] got;
    logic late = 1'b0;
    task automatic send(input logic [7:0] b, input logic stp);
        for (int i = 0; i < 10; i++) begin
            line_o <= (i == 0) ? 1'b0 : (i == 9) ? stp : b[i-1];
            repeat (16) @(posedge clk_i);
        end
        line_o <= 1'b1;
        @(posedge clk_i);
    endtask
    // Mid-bit sampling from the first low seen
    task automatic recv;
        got = 8'hxx;
        for (int n = 0; n < 4000 && line_i; n++) @(posedge clk_i);
        late = line_i;
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clk_i);
            got[i] = line_i;
        end
        repeat (16) @(posedge clk_i);
    endtask
endmodule

// ### testbench/ufc_channel_test.sv
/* Bench for one UART channel at base 0x00.
   Assumes the remote model and one 16X tick per clock. */
`timescale 1ns/100ps
module ufc_channel_test import ufc_pkg::*; ;
    localparam int EXP_WAIT = (TIMEOUT_WORDS * (MIN_WORD_BITS + 3) + TIMEOUT_EXTRA_BITS) * TICKS_PER_BIT;
    logic clk = 1'b0, arst_n = 1'b0, we = 1'b0, re = 1'b0, cts_n = 1'b0, ready, tx, rx, rts_n, dtr_n;
    logic [7:0] addr = 8'h00, wd = 8'h00, fifo_control = 8'h01, interrupt_enable = 8'h00, modem_control = 8'h00, enhanced_feature = 8'h00, rdata, line_status, interrupt_source;
    logic [6:0] trg = 7'h01;
    int bad_count = 0, tests_run = 0, n;
    wire logic [15:0] flags = {interrupt_source, line_status};
    ufc_channel u_ufc_channel (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .BUS_ADDR_I(addr), .BUS_WR_I(we),
        .BUS_RD_I(re), .BUS_WDATA_I(wd), .BUS_RDATA_O(rdata), .BUS_WR_READY_O(ready), .LINE_CONTROL_I(8'h03),
        .FIFO_CONTROL_I(fifo_control), .INT_ENABLE_I(interrupt_enable), .MODEM_CONTROL_I(modem_control), .ENH_FEATURE_I(enhanced_feature),
        .FEATURE_CONTROL_I(8'h00), .TRIG_TABLE_D_I(1'b0), .RX_TRIGGER_I(trg), .RX_TRIG_UP_I(trg),
        .RX_TRIG_DOWN_I(trg), .TX_TRIGGER_I(trg), .BAUD_DIVISOR_I(16'h0001), .FLOW_INT_CLR_I(1'b0),
        .TX_O(tx), .RX_I(rx), .RTS_N_O(rts_n), .DTR_N_O(dtr_n), .CTS_N_I(cts_n), .DSR_N_I(cts_n),
        .LINE_STATUS_O(line_status), .INT_SOURCE_O(interrupt_source));
    ufc_remote u_ufc_remote (.clk_i(clk), .line_i(tx), .line_o(rx));
    initial forever #2.5 clk = ~clk;
    ////////////////////////////////////////
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task automatic wt(input int b);
        @(negedge clk);
        for (n = 0; flags[b] !== 1'b1; n++) begin
            if (n > 2000) begin
                bad_count++;
                report_and_stop();
            end
            @(negedge clk);
        end
        @(posedge clk);
    endtask
    // Holds the write until ready is seen high at a falling edge
    task automatic wr(input logic [7:0] d);
        int k;
        @(posedge clk);
        we <= 1'b1;
        wd <= d;
        @(negedge clk);
        for (k = 0; ready !== 1'b1; k++) begin
            if (k > 2000) begin
                bad_count++;
                report_and_stop();
            end
            @(negedge clk);
        end
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rcv(input logic [7:0] e);
        u_ufc_remote.recv();
        if (u_ufc_remote.late) begin
            bad_count++;
            report_and_stop();
        end
        chk(u_ufc_remote.got, e);
    endtask
    task automatic rd(input logic [7:0] e);
        @(posedge clk);
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(posedge clk);
        chk(rdata, e);
        @(posedge clk);
    endtask
    task automatic report_and_stop;
        $display("%0d checks, %0d wrong", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic t_tx;
        addr <= 8'h10;
        wr(8'hee);
        addr <= 8'h00;
        wr(8'ha5);
        wr(8'h3c);
        @(negedge clk);
        chk(line_status & 8'h40, 8'h00);
        rcv(8'ha5);
        rcv(8'h3c);
        fifo_control <= 8'h00;
        wr(8'h96);
        rcv(8'h96);
        wt(LSR_TX_EMPTY);
        fifo_control <= 8'h01;
    endtask
    task automatic t_rx;
        interrupt_enable <= 8'h01;
        u_ufc_remote.send(8'h5a, 1'b1);
        u_ufc_remote.send(8'h00, 1'b0);
        wt(8 + ISR_RX_TIMEOUT);
        chk({7'h00, n > EXP_WAIT - 16 && n < EXP_WAIT + 16}, 8'h01);
        chk(interrupt_source & 8'h01, 8'h01);
        rd(8'h5a);
        chk(line_status & 8'h1c, 8'h18);
        rd(8'h00);
        chk(line_status & 8'h1d, 8'h00);
    endtask
    // Second byte must wait while the first finishes under a raised clear-to-send
    task automatic t_flow;
        interrupt_enable <= 8'hc0;
        enhanced_feature <= 8'h90;
        wr(8'h69);
        wr(8'h2d);
        cts_n <= 1'b1;
        rcv(8'h69);
        repeat (200) @(posedge clk);
        chk({6'h00, tx, line_status[5]}, 8'h02);
        modem_control <= 8'h02;
        cts_n <= 1'b0;
        rcv(8'h2d);
        chk({5'h00, interrupt_source[5], rts_n, dtr_n}, 8'h05);
        enhanced_feature <= 8'hd0;
        u_ufc_remote.send(8'hc3, 1'b1);
        u_ufc_remote.send(8'h3c, 1'b1);
        chk({7'h00, rts_n}, 8'h01);
        rd(8'hc3);
        rd(8'h3c);
        repeat (2) @(posedge clk);
        chk({7'h00, rts_n}, 8'h00);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_tx();
        t_rx();
        t_flow();
        report_and_stop();
    end
endmodule
